// ### hw/dst_stamp_irq.sv
// Data-enable stamping and interrupt pin routing with an AXI4-Lite register slave
//
// Operation
// - Level stamping when level_enable_a is 1 and level_enable_b is 0.
// - Level mode puts the active data-enable level into selected sample LSBs.
// - Data-enable is sampled just before each sample update; later changes wait.
// - Both enables set gives latched mode: LSB 1 only after a pulse.
// - Only axes whose select bit is 1 get stamped, on chosen sensor.
// - Sensor select 0 stamps gyroscope axes, 1 stamps accelerometer axes.
// - After reset all three gyroscope axes are selected.
// - Motion events come from accelerometer only; host keeps it active.
// - Under in-band interrupts the pins drive only when pin enable set.
// - Polarity 0 gives active-high pins, 1 gives active-low pins.
// - Drive type 0 is push-pull, 1 drives only the asserted state.
// - Two interrupt pins, each with its own pair of routing registers.
// - Routing bits reset to 0; a source reaches a pin only when set.
// - First-pin FIFO routing register layout; bits 7 and 2 read 0.
// - First-pin event routing register layout of eight event sources.
// - Every source routes independently; all but the first-pin FIFO sources stay readable as status.
// - Any stamping mode turns the second pin into the data-enable input.
// - Data-enable is active low unless input polarity bit is 1.
// - Stamping covers gyroscope only unless accel extension bit is 1.
// - Several routed sources drive the pin with their logical OR.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "dst_params.svh"

module dst_stamp_irq
  import dst_pkg::*;
(
  input wire logic clock, // 100 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic gyro_update, // Pulse: gyroscope sample about to be written
  input wire logic accel_update, // Pulse: accelerometer sample about to be written
  input wire dst_axes_t gyro_raw, // Gyroscope sample before stamping
  input wire dst_axes_t accel_raw, // Accelerometer sample before stamping
  output dst_axes_t gyro_out, // Stamped gyroscope sample
  output dst_axes_t accel_out, // Stamped accelerometer sample
  input wire logic [7:0] fifo_srcs, // FIFO and data-ready sources, route layout
  input wire logic [7:0] event_srcs, // Accelerometer-derived event sources
  input wire logic [7:0] second_fifo_srcs, // Sources for second-pin FIFO routing
  input wire logic [7:0] second_event_srcs, // Sources for second-pin event routing
  input wire logic ibi_mode, // In-band interrupt bus is in use
  output logic first_irq_pin_o, // First pin output level
  output logic first_irq_pin_oe, // First pin output enable
  input wire logic second_irq_pin_i, // Second pin level from the pad
  output logic second_irq_pin_o, // Second pin output level
  output logic second_irq_pin_oe // Second pin output enable
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] first_pin_fifo_drdy_route;
  logic [7:0] first_pin_event_route;
  logic [7:0] second_pin_fifo_route;
  logic [7:0] second_pin_event_route;
  logic [7:0] stamp_cfg;
  logic [7:0] pin_cfg;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic den_sync_a;
  logic den_sync_b;
  logic den_prev;
  logic pulse_flag;
  logic gyro_stamp_bit;
  logic accel_stamp_bit;
  logic level_enable_a;
  logic level_enable_b;
  logic stamp_accel_extend;
  logic stamp_sensor_sel;
  logic stamp_input_polarity;
  logic [2:0] axis_sel;
  logic irq_pin_polarity;
  logic irq_pin_drive_type;
  logic pins_live;
  logic den_active;
  logic stamping_on;
  logic first_irq;
  logic second_irq;
  logic do_write;
  logic [2:0] input_age;
  logic den_fresh;
  dst_mode_t mode;

  // Field decode of the configuration registers
  assign level_enable_a = stamp_cfg[`DST_BIT_LVL_A];
  assign level_enable_b = stamp_cfg[`DST_BIT_LVL_B];
  assign stamp_accel_extend = stamp_cfg[`DST_BIT_XL_EXT];
  assign axis_sel = {stamp_cfg[`DST_BIT_AX_Z], stamp_cfg[`DST_BIT_AX_Y], stamp_cfg[`DST_BIT_AX_X]};
  assign stamp_sensor_sel = stamp_cfg[`DST_BIT_SENSOR];
  assign stamp_input_polarity = stamp_cfg[`DST_BIT_IN_POL];
  assign irq_pin_polarity = pin_cfg[`DST_BIT_PIN_POL];
  assign irq_pin_drive_type = pin_cfg[`DST_BIT_PIN_OD];

  // Mode from the two enables; b set without a is treated as off
  always_comb begin
    if (level_enable_a && !level_enable_b) begin
      mode = DST_LEVEL;
    end else if (level_enable_a && level_enable_b) begin
      mode = DST_LATCH;
    end else begin
      mode = DST_OFF;
    end
  end
  assign stamping_on = (mode != DST_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Stamp one sample; unselected axes pass untouched
  function automatic dst_axes_t stamp_axes(input dst_axes_t raw, input logic [2:0] sel, input logic bit_in,
                                           input logic en);
    dst_axes_t res;
    res = raw;
    if (en) begin
      if (sel[0]) res.x[0] = bit_in;
      if (sel[1]) res.y[0] = bit_in;
      if (sel[2]) res.z[0] = bit_in;
    end
    return res;
  endfunction : stamp_axes

  // One address decode for both bus sides, so writes and reads agree on the map
  function automatic logic reg_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      `DST_OFF_FIFO_ROUTE, `DST_OFF_EVENT_ROUTE, `DST_OFF_SECOND_ROUTE, `DST_OFF_SECOND_EVENT: hit = 1'b1;
      `DST_OFF_STAMP_CFG, `DST_OFF_PIN_CFG, `DST_OFF_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////
  // Data-enable pad sync; first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      den_sync_a <= 1'b1;
      den_sync_b <= 1'b1;
    end else begin
      den_sync_a <= second_irq_pin_i;
      den_sync_b <= den_sync_a;
    end
  end

  // Active low unless the input polarity bit is set
  assign den_active = stamp_input_polarity ? den_sync_b : !den_sync_b;

  // Previous active state for pulse detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      den_prev <= 1'b0;
    end else begin
      den_prev <= den_active;
    end
  end

  // Pad age since it became an input; the sync stages still hold the level that
  // the block itself drove, so edges and levels count once fresh samples arrive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      input_age <= 3'h0;
    end else begin
      input_age <= {input_age[1:0], stamping_on};
    end
  end
  assign den_fresh = &input_age;

  // Pulse flag: a pulse counts at its trailing edge; a new pulse wins over the clear
  // Edges during the pad handover are stale driven levels and are ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_flag <= 1'b0;
    end else if (mode != DST_LATCH) begin
      pulse_flag <= 1'b0;
    end else if (den_fresh && den_prev && !den_active) begin
      pulse_flag <= 1'b1;
    end else if ((gyro_update && !stamp_sensor_sel) || (accel_update && stamp_sensor_sel)) begin
      pulse_flag <= 1'b0;
    end
  end

  // Stamp value frozen at the update instant; later changes wait a sample
  // Until fresh pad samples arrive the level counts as inactive
  always_comb begin
    gyro_stamp_bit = (mode == DST_LATCH) ? pulse_flag : (den_active && den_fresh);
    accel_stamp_bit = gyro_stamp_bit;
  end

  // Gyroscope output sample register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gyro_out <= '0;
    end else if (gyro_update) begin
      gyro_out <= stamp_axes(gyro_raw, axis_sel, gyro_stamp_bit, stamping_on && !stamp_sensor_sel);
    end
  end

  // Accelerometer samples only stamped when extension is on; host keeps rates aligned
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accel_out <= '0;
    end else if (accel_update) begin
      accel_out <= stamp_axes(accel_raw, axis_sel, accel_stamp_bit,
                              stamping_on && stamp_sensor_sel && stamp_accel_extend);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin routing: OR of routed sources; events are accelerometer-derived
  assign first_irq = |(first_pin_fifo_drdy_route & fifo_srcs) |
                     |(first_pin_event_route & event_srcs);
  assign second_irq = |(second_pin_fifo_route & second_fifo_srcs) |
                      |(second_pin_event_route & second_event_srcs);
  assign pins_live = !ibi_mode || pin_cfg[`DST_BIT_PIN_EN];

  // Pin drivers; open drain releases the idle level
  // The second pin stays released while it serves as the data-enable input
  always_comb begin
    first_irq_pin_o = first_irq ^ irq_pin_polarity;
    first_irq_pin_oe = pins_live && (!irq_pin_drive_type || first_irq);
    second_irq_pin_o = second_irq ^ irq_pin_polarity;
    second_irq_pin_oe = pins_live && !stamping_on && (!irq_pin_drive_type || second_irq);
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data taken in either order
  // Readies drop while a response waits, so one write at most is in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries data
  // Status and unmapped offsets take no write; only unmapped ones answer SLVERR
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_pin_fifo_drdy_route <= `DST_ROUTE_RESET;
      first_pin_event_route <= `DST_ROUTE_RESET;
      second_pin_fifo_route <= `DST_ROUTE_RESET;
      second_pin_event_route <= `DST_ROUTE_RESET;
      stamp_cfg <= `DST_STAMP_RESET;
      pin_cfg <= `DST_PIN_RESET;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        `DST_OFF_FIFO_ROUTE: first_pin_fifo_drdy_route <= w_data[7:0] & `DST_FIFO_ROUTE_MASK;
        `DST_OFF_EVENT_ROUTE: first_pin_event_route <= w_data[7:0];
        `DST_OFF_SECOND_ROUTE: second_pin_fifo_route <= w_data[7:0];
        `DST_OFF_SECOND_EVENT: second_pin_event_route <= w_data[7:0];
        `DST_OFF_STAMP_CFG: stamp_cfg <= w_data[7:0];
        `DST_OFF_PIN_CFG: pin_cfg <= w_data[7:0];
        default: ;
      endcase
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DST_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_mapped(aw_addr) ? `DST_RESP_OKAY : `DST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side; status shows live sources, pin states and stamp flag
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_mapped(s_axi_araddr) ? `DST_RESP_OKAY : `DST_RESP_SLVERR;
      unique case (s_axi_araddr)
        `DST_OFF_FIFO_ROUTE: s_axi_rdata <= {24'h000000, first_pin_fifo_drdy_route};
        `DST_OFF_EVENT_ROUTE: s_axi_rdata <= {24'h000000, first_pin_event_route};
        `DST_OFF_SECOND_ROUTE: s_axi_rdata <= {24'h000000, second_pin_fifo_route};
        `DST_OFF_SECOND_EVENT: s_axi_rdata <= {24'h000000, second_pin_event_route};
        `DST_OFF_STAMP_CFG: s_axi_rdata <= {24'h000000, stamp_cfg};
        `DST_OFF_PIN_CFG: s_axi_rdata <= {24'h000000, pin_cfg};
        `DST_OFF_STATUS: s_axi_rdata <= {4'h0, pulse_flag, second_irq, first_irq, den_active,
                                         second_event_srcs, second_fifo_srcs, event_srcs};
        default: begin
          s_axi_rdata <= 32'h0000_0000; // Unmapped reads return zero with an error
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dst_stamp_irq

// ### inc/dst_params.svh
// Register offsets, field positions and reset values of the stamping and pin block
`ifndef DST_PARAMS_SVH
`define DST_PARAMS_SVH
`define DST_OFF_FIFO_ROUTE 8'h00
`define DST_OFF_EVENT_ROUTE 8'h04
`define DST_OFF_SECOND_ROUTE 8'h08
`define DST_OFF_SECOND_EVENT 8'h0C
`define DST_OFF_STAMP_CFG 8'h10
`define DST_OFF_PIN_CFG 8'h14
`define DST_OFF_STATUS 8'h18
`define DST_FIFO_ROUTE_MASK 8'h7B
`define DST_ROUTE_RESET 8'h00
// Stamp configuration field positions
`define DST_BIT_LVL_A 0
`define DST_BIT_LVL_B 1
`define DST_BIT_XL_EXT 2
`define DST_BIT_AX_X 3
`define DST_BIT_AX_Y 4
`define DST_BIT_AX_Z 5
`define DST_BIT_SENSOR 6
`define DST_BIT_IN_POL 7
`define DST_STAMP_RESET 8'h38
// Pin configuration field positions
`define DST_BIT_PIN_POL 0
`define DST_BIT_PIN_OD 1
`define DST_BIT_PIN_EN 2
`define DST_PIN_RESET 8'h00
`define DST_RESP_OKAY 2'h0
`define DST_RESP_SLVERR 2'h2
`endif

// ### inc/dst_pkg.sv
// Types shared by the stamping and pin block
package dst_pkg;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } dst_axes_t;
  typedef enum logic [1:0] {
    DST_OFF = 2'h0,
    DST_LEVEL = 2'h1,
    DST_LATCH = 2'h3
  } dst_mode_t;
endpackage : dst_pkg

// ### tb/dst_stamp_irq_props.sv
// Port-level assertions of the stamping and pin block
`timescale 1ns/10ps
module dst_stamp_irq_props
  import dst_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic gyro_update, // Gyro strobe
  input wire logic accel_update, // Accel strobe
  input wire dst_axes_t gyro_raw, // Gyro in
  input wire dst_axes_t accel_raw, // Accel in
  input wire dst_axes_t gyro_out, // Gyro out
  input wire dst_axes_t accel_out // Accel out
);
  // Everything above the stamped LSBs
  localparam logic [47:0] HI = 48'hFFFEFFFEFFFE;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Stamping may touch only the LSB, and only at an update
  gyro_body_a: assert property (gyro_update |=> (gyro_out & HI) == ($past(gyro_raw) & HI))
    else $error("gyro sample body altered");
  accel_body_a: assert property (accel_update |=> (accel_out & HI) == ($past(accel_raw) & HI))
    else $error("accel sample body altered");
  gyro_hold_a: assert property (!gyro_update |=> $stable(gyro_out))
    else $error("gyro output moved without update");
  accel_hold_a: assert property (!accel_update |=> $stable(accel_out))
    else $error("accel output moved without update");
  ////////////////////////////////////////////////////////////////
  // Register bus answers stand until taken
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  cover property (gyro_update && accel_update);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : dst_stamp_irq_props

bind dst_stamp_irq dst_stamp_irq_props dst_stamp_irq_props_i (.clock(clock), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .gyro_update(gyro_update), .accel_update(accel_update), .gyro_raw(gyro_raw), .accel_raw(accel_raw),
  .gyro_out(gyro_out), .accel_out(accel_out));

// ### tb/dst_host_model.sv
// Host-side model of the second interrupt pad
`timescale 1ns/10ps
module dst_host_model (
  input wire logic second_irq_pin_o, // Block drive level
  input wire logic second_irq_pin_oe, // Block drive enable
  input wire logic den_level, // Host data-enable level
  output logic second_irq_pin_i // Resolved pad level
);
  // Host drives data-enable only once the block lets go, so no contention
  assign second_irq_pin_i = second_irq_pin_oe ? second_irq_pin_o : den_level;
endmodule : dst_host_model

// ### tb/dst_stamp_irq_bench.sv
// Self-checking bench of the stamping and pin block
`timescale 1ns/10ps
`include "dst_params.svh"
module dst_stamp_irq_bench import dst_pkg::*;;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fifo_srcs = 8'h00, event_srcs = 8'h00;
  logic [7:0] second_fifo_srcs = 8'h00, second_event_srcs = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, gyro_update = 1'h0, accel_update = 1'h0, ibi_mode = 1'h0, data_enable_input = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic first_irq_pin_o, first_irq_pin_oe, second_irq_pin_i, second_irq_pin_o, second_irq_pin_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, e;
  logic [7:0] r [4];
  dst_axes_t gyro_raw = 48'h0, accel_raw = 48'h0, gyro_out, accel_out;
  int n_mismatch = 0, tests_run = 0, seed = 64662, i;

  always #5 clock = ~clock;
  dst_stamp_irq dst_stamp_irq_i (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .gyro_update(gyro_update), .accel_update(accel_update), .gyro_raw(gyro_raw), .accel_raw(accel_raw),
    .gyro_out(gyro_out), .accel_out(accel_out), .fifo_srcs(fifo_srcs), .event_srcs(event_srcs),
    .second_fifo_srcs(second_fifo_srcs), .second_event_srcs(second_event_srcs), .ibi_mode(ibi_mode),
    .first_irq_pin_o(first_irq_pin_o), .first_irq_pin_oe(first_irq_pin_oe), .second_irq_pin_i(second_irq_pin_i),
    .second_irq_pin_o(second_irq_pin_o), .second_irq_pin_oe(second_irq_pin_oe));
  dst_host_model dst_host_model_i (.second_irq_pin_o(second_irq_pin_o), .second_irq_pin_oe(second_irq_pin_oe),
    .den_level(data_enable_input), .second_irq_pin_i(second_irq_pin_i));
  ////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task report_and_stop;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Bus cycles; a stuck handshake ends the run
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int k;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (k == 50) begin
      chk("write wait", 1, 0);
      report_and_stop;
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int k;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (k == 50) begin
      chk("read wait", 1, 0);
      report_and_stop;
    end
  endtask : axr
  ////////////////////////////////////////////////////////////////
  // Expected sample after stamping bit b into the selected LSBs
  function automatic dst_axes_t stamp(input dst_axes_t v, input logic [2:0] s, input logic b);
    if (s[0]) v.x[0] = b;
    if (s[1]) v.y[0] = b;
    if (s[2]) v.z[0] = b;
    return v;
  endfunction : stamp
  // Expected {oe, level} of a pin; level only matters while driven
  function automatic logic [1:0] pin(input logic a, input logic [2:0] c, input logic ibi);
    if (ibi && !c[2]) return 2'h0;
    if (c[1]) return {a, !c[0]};
    return {1'h1, a ^ c[0]};
  endfunction : pin
  // Both sensors update together, as the host must keep one rate
  task automatic samp(input int w, input logic acc, input logic [2:0] s, input logic b);
    repeat (w) @(posedge clock);
    gyro_raw <= dst_axes_t'(48'({$random(seed), $random(seed)}));
    accel_raw <= dst_axes_t'(48'({$random(seed), $random(seed)}));
    gyro_update <= 1'h1;
    accel_update <= 1'h1;
    @(posedge clock);
    gyro_update <= 1'h0;
    accel_update <= 1'h0;
    #1;
    chk("gyro sample", stamp(gyro_raw, acc ? 3'h0 : s, b), gyro_out);
    chk("accel sample", stamp(accel_raw, acc ? s : 3'h0, b), accel_out);
  endtask : samp
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 6; i++) begin
      axr(8'(4 * i), rd, rs);
      chk("reset value", (i == 4) ? `DST_STAMP_RESET : 8'h00, rd);
    end
    // A write without byte lane 0 leaves the routing bits alone
    s_axi_wstrb <= 4'hE;
    axw(`DST_OFF_EVENT_ROUTE, 32'hFF, rs);
    s_axi_wstrb <= 4'hF;
    axr(`DST_OFF_EVENT_ROUTE, rd, rs);
    chk("lane 0 off", 8'h00, rd);
    axr(8'h1C, rd, rs);
    chk("unmapped read", `DST_RESP_SLVERR, rs);
    axw(8'h1C, 32'hFF, rs);
    chk("unmapped write", `DST_RESP_SLVERR, rs);
    // Every polarity, drive type and in-band setting with random routes; events are accel-derived
    for (i = 0; i < 16; i++) begin
      ibi_mode <= i[3];
      for (int k = 0; k < 4; k++) r[k] = 8'($random(seed));
      for (int k = 0; k < 4; k++) axw(8'(4 * k), {24'h0, r[k]}, rs);
      axw(`DST_OFF_PIN_CFG, 32'(i[2:0]), rs);
      axr(`DST_OFF_FIFO_ROUTE, rd, rs);
      chk("fifo route", r[0] & `DST_FIFO_ROUTE_MASK, rd);
      axr(`DST_OFF_EVENT_ROUTE, rd, rs);
      chk("event route", r[1], rd);
      fifo_srcs <= 8'($random(seed) & $random(seed));
      event_srcs <= 8'($random(seed) & $random(seed));
      second_fifo_srcs <= 8'($random(seed) & $random(seed)) & `DST_FIFO_ROUTE_MASK;
      second_event_srcs <= 8'($random(seed) & $random(seed));
      @(posedge clock);
      e = pin(|(fifo_srcs & r[0] & `DST_FIFO_ROUTE_MASK) || |(event_srcs & r[1]), i[2:0], i[3]);
      chk("first oe", e[1], first_irq_pin_oe);
      if (e[1]) chk("first level", e[0], first_irq_pin_o);
      e = pin(|(second_fifo_srcs & r[2]) || |(second_event_srcs & r[3]), i[2:0], i[3]);
      chk("second oe", e[1], second_irq_pin_oe);
      if (e[1]) chk("second level", e[0], second_irq_pin_o);
    end
    axr(`DST_OFF_STATUS, rd, rs);
    chk("status", {second_event_srcs, second_fifo_srcs, event_srcs}, rd[23:0]);
    ibi_mode <= 1'h0;
    axw(`DST_OFF_PIN_CFG, 32'h0, rs);
    // Level stamping into all gyro axes, data-enable active low
    axw(`DST_OFF_STAMP_CFG, 32'h39, rs);
    chk("pin turned input", 0, second_irq_pin_oe);
    data_enable_input <= 1'h0;
    samp(4, 1'h0, 3'h7, 1'h1);
    data_enable_input <= 1'h1;
    samp(1, 1'h0, 3'h7, 1'h1);
    samp(4, 1'h0, 3'h7, 1'h0);
    // Latched stamping: one marked sample per pulse
    axw(`DST_OFF_STAMP_CFG, 32'h3B, rs);
    samp(4, 1'h0, 3'h7, 1'h0);
    data_enable_input <= 1'h0;
    repeat (4) @(posedge clock);
    data_enable_input <= 1'h1;
    samp(4, 1'h0, 3'h7, 1'h1);
    samp(4, 1'h0, 3'h7, 1'h0);
    // Active-high data-enable, random axes on either sensor
    for (i = 0; i < 8; i++) begin
      rd = 32'($random(seed));
      data_enable_input <= rd[3];
      axw(`DST_OFF_STAMP_CFG, {24'h0, 1'h1, rd[0], rd[6:4], rd[1], 2'h1}, rs);
      samp(4, rd[0], (rd[0] && !rd[1]) ? 3'h0 : rd[6:4], rd[3]);
    end
    // Stamping off hands the second pin back; level_enable_b alone is still off
    second_fifo_srcs <= 8'h00;
    second_event_srcs <= 8'h00;
    data_enable_input <= 1'h1;
    axw(`DST_OFF_STAMP_CFG, 32'h3A, rs);
    samp(4, 1'h0, 3'h0, 1'h0);
    chk("pin output again", 1, second_irq_pin_oe);
    // Straight into latched mode: the pad handover is no pulse
    axw(`DST_OFF_STAMP_CFG, 32'h3B, rs);
    samp(4, 1'h0, 3'h7, 1'h0);
    report_and_stop;
  end
endmodule : dst_stamp_irq_bench
